//--- design/mic_irq_ctrl.v
/*
 Interrupt controller of a small 8-bit microcontroller, with AXI4-Lite
 register access, sticky event status and sleep wake-up.
 Assumes the core sequencer reports instruction boundaries, the return
 instruction and sleep, and takes the vector on pc_load.
*/
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_irq_ctrl (
	// Clock and reset
	input wire clk,
	input wire srst,
	// AXI4-Lite write channels
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read channels
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Pins
	input wire external_irq_pin,
	input wire [3:0] second_io_port_hi,
	// Peripherals
	input wire timer_zero_overflow,
	input wire ee_write_done_flag,
	// Core sequencer
	input wire instr_boundary,
	input wire return_from_irq_instr,
	input wire sleep_instr,
	input wire [12:0] return_pc,
	output reg pc_load,
	output reg [12:0] pc_load_value,
	output reg core_asleep,
	// Interrupt output
	output reg irq_out
);
	// ----------------------------------------------------------------
	// State and registers
	// ----------------------------------------------------------------
	localparam ST_RUN = 2'h0;
	localparam ST_SLEEP = 2'h1;
	localparam ST_WAKE = 2'h2;

	reg [7:0] interrupt_control_reg, option_reg, awaddr_reg;
	reg [3:0] evt_status_reg, evt_enable_reg, port_prev_reg;
	reg [1:0] state_reg, tcy_cnt_reg;
	reg [12:0] pc_shadow_reg;
	reg [31:0] wdata_reg;
	reg tcy_tick_reg, pin_prev_reg, sync_valid_reg, aw_held_reg, w_held_reg;
	reg stack_push, stack_pop;

	wire [3:0] port_lvl, pend, evt;
	wire [12:0] stack_top;
	wire [7:0] hw_flags;
	wire pin_lvl, pin_edge, port_change, global_irq_enable, any_pend, take_irq;
	wire wr_fire, rd_fire, wr_ctrl;

	assign global_irq_enable = interrupt_control_reg[`MIC_B_GIE];

	// ----------------------------------------------------------------
	// Input synchronisers and return stack
	// ----------------------------------------------------------------
	mic_sync3 #(.W(5)) u_sync (
		.clk(clk),
		.srst(srst),
		.pin_in({external_irq_pin, second_io_port_hi}),
		.level({pin_lvl, port_lvl})
	);

	mic_stack u_stack (
		.clk(clk),
		.srst(srst),
		.push(stack_push),
		.push_data(pc_shadow_reg),
		.pop(stack_pop),
		.top_data(stack_top)
	);

	// ----------------------------------------------------------------
	// Instruction cycle enable
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			tcy_cnt_reg <= 2'h0;
			tcy_tick_reg <= 1'b0;
		end else begin
			tcy_cnt_reg <= tcy_cnt_reg + 2'h1;
			tcy_tick_reg <= (tcy_cnt_reg == `MIC_TCY_CYC - 1);
		end
	end

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			pin_prev_reg <= 1'b0;
			port_prev_reg <= 4'h0;
			sync_valid_reg <= 1'b0;
		end else begin
			pin_prev_reg <= pin_lvl;
			sync_valid_reg <= 1'b1;
			// Port pins are compared once per instruction cycle
			if (tcy_tick_reg) begin
				port_prev_reg <= port_lvl;
			end
		end
	end

	assign pin_edge = sync_valid_reg && (option_reg[`MIC_B_EDGE] ?
		(pin_lvl && !pin_prev_reg) : (!pin_lvl && pin_prev_reg));
	assign port_change = sync_valid_reg && tcy_tick_reg &&
		(port_lvl != port_prev_reg);
	assign evt = {ee_write_done_flag, timer_zero_overflow, pin_edge,
		port_change};
	assign hw_flags = {5'h00, timer_zero_overflow, pin_edge, port_change};

	assign pend[0] = interrupt_control_reg[`MIC_B_PORT_FLAG] &&
		interrupt_control_reg[`MIC_B_PORT_EN];
	assign pend[1] = interrupt_control_reg[`MIC_B_PIN_FLAG] &&
		interrupt_control_reg[`MIC_B_PIN_EN];
	assign pend[2] = interrupt_control_reg[`MIC_B_TMR_FLAG] &&
		interrupt_control_reg[`MIC_B_TMR_EN];
	assign pend[3] = ee_write_done_flag &&
		interrupt_control_reg[`MIC_B_EE_EN];
	assign any_pend = |pend;
	assign take_irq = global_irq_enable && any_pend && !pc_load &&
		state_reg == ST_RUN && instr_boundary;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_ctrl = wr_fire && (awaddr_reg == `MIC_OFF_CTRL) &&
		wdata_reg[31];

	always @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MIC_AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				// Only byte lane 0 carries data; bit 31 marks it written
				wdata_reg <= {s_axi_wstrb[0], 23'h000000,
					s_axi_wdata[7:0]};
				w_held_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_reg == `MIC_OFF_CTRL ||
					awaddr_reg == `MIC_OFF_OPTION ||
					awaddr_reg == `MIC_OFF_CLR ||
					awaddr_reg == `MIC_OFF_IEN) begin
					s_axi_bresp <= `MIC_AXI_OKAY;
				end else begin
					s_axi_bresp <= `MIC_AXI_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `MIC_AXI_OKAY;
		end else if (rd_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `MIC_AXI_OKAY;
			if (s_axi_araddr == `MIC_OFF_CTRL) begin
				s_axi_rdata <= {24'h000000, interrupt_control_reg};
			end else if (s_axi_araddr == `MIC_OFF_OPTION) begin
				s_axi_rdata <= {24'h000000, option_reg};
			end else if (s_axi_araddr == `MIC_OFF_STAT) begin
				s_axi_rdata <= {28'h0000000, evt_status_reg};
			end else if (s_axi_araddr == `MIC_OFF_CLR) begin
				s_axi_rdata <= 32'h00000000;
			end else if (s_axi_araddr == `MIC_OFF_IEN) begin
				s_axi_rdata <= {28'h0000000, evt_enable_reg};
			end else if (s_axi_araddr == `MIC_OFF_CORE) begin
				s_axi_rdata <= {16'h0000, core_asleep, state_reg,
					pc_load_value};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `MIC_AXI_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Control and option registers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			interrupt_control_reg <= `MIC_CTRL_RST;
			option_reg <= `MIC_OPTION_RST;
		end else begin
			if (wr_fire && awaddr_reg == `MIC_OFF_OPTION && wdata_reg[31])
				begin
				option_reg <= wdata_reg[7:0];
			end
			// Hardware flag sets win over a software write of zero
			if (wr_ctrl) begin
				interrupt_control_reg <= wdata_reg[7:0] | hw_flags;
			end else begin
				interrupt_control_reg <= interrupt_control_reg |
					hw_flags;
			end
			if (take_irq) begin
				interrupt_control_reg[`MIC_B_GIE] <= 1'b0;
			end else if (return_from_irq_instr && state_reg == ST_RUN) begin
				interrupt_control_reg[`MIC_B_GIE] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Event status, enables and interrupt line
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			evt_status_reg <= 4'h0;
			evt_enable_reg <= 4'h0;
			irq_out <= 1'b0;
		end else begin
			if (wr_fire && awaddr_reg == `MIC_OFF_IEN && wdata_reg[31]) begin
				evt_enable_reg <= wdata_reg[3:0];
			end
			// New events win over a clear in the same cycle
			if (wr_fire && awaddr_reg == `MIC_OFF_CLR && wdata_reg[31]) begin
				evt_status_reg <= (evt_status_reg & ~wdata_reg[3:0]) | evt;
			end else begin
				evt_status_reg <= evt_status_reg | evt;
			end
			irq_out <= |(evt_status_reg & evt_enable_reg);
		end
	end

	// ----------------------------------------------------------------
	// Sequencer: entry, return and sleep
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_RUN;
			core_asleep <= 1'b0;
			pc_load <= 1'b0;
			pc_load_value <= `MIC_PC_RST;
			pc_shadow_reg <= `MIC_PC_RST;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
		end else begin
			pc_load <= 1'b0;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			if (take_irq) begin
				// Only the return address is kept; no other context
				pc_shadow_reg <= return_pc;
				stack_push <= 1'b1;
				pc_load <= 1'b1;
				pc_load_value <= `MIC_VECTOR;
				state_reg <= ST_RUN;
			end else if (return_from_irq_instr && state_reg == ST_RUN) begin
				stack_pop <= 1'b1;
			end else if (stack_pop == 1'b0 && state_reg == ST_RUN &&
				sleep_instr && !any_pend) begin
				state_reg <= ST_SLEEP;
				core_asleep <= 1'b1;
			end else if (state_reg == ST_SLEEP && any_pend) begin
				// Enabled source wakes; global enable picks the path
				core_asleep <= 1'b0;
				state_reg <= global_irq_enable ? ST_WAKE : ST_RUN;
			end else if (state_reg == ST_WAKE && instr_boundary) begin
				state_reg <= ST_RUN;
			end
			// Return address appears one cycle after the pop
			if (stack_pop) begin
				pc_load <= 1'b1;
				pc_load_value <= stack_top;
			end
		end
	end
endmodule

//--- design/mic_defs.vh
/*
 Constants of the interrupt controller: register offsets, bit positions,
 reset values and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MIC_OFF_CTRL 8'h00
`define MIC_OFF_OPTION 8'h04
`define MIC_OFF_STAT 8'h08
`define MIC_OFF_CLR 8'h0C
`define MIC_OFF_IEN 8'h10
`define MIC_OFF_CORE 8'h14

// ----------------------------------------------------------------
// Control and option register bit positions
// ----------------------------------------------------------------
`define MIC_B_PORT_FLAG 0
`define MIC_B_PIN_FLAG 1
`define MIC_B_TMR_FLAG 2
`define MIC_B_PORT_EN 3
`define MIC_B_PIN_EN 4
`define MIC_B_TMR_EN 5
`define MIC_B_EE_EN 6
`define MIC_B_GIE 7
`define MIC_B_EDGE 6

// ----------------------------------------------------------------
// Reset values and interrupt vector
// ----------------------------------------------------------------
`define MIC_CTRL_RST 8'h00
`define MIC_OPTION_RST 8'hFF
`define MIC_VECTOR 13'h0004
`define MIC_PC_RST 13'h0000

// ----------------------------------------------------------------
// Timing, stack depth and bus response codes
// ----------------------------------------------------------------
`define MIC_CLK_NS 5
`define MIC_TCY_NS 20
`define MIC_TCY_CYC (`MIC_TCY_NS / `MIC_CLK_NS)
`define MIC_STACK_DEPTH 8
`define MIC_AXI_OKAY 2'h0
`define MIC_AXI_SLVERR 2'h2

`endif

//--- design/mic_sync3.v
/*
 Three-flop input synchroniser with agreement filter for a vector.
 Assumes the inputs come from pins outside the clk domain.
*/
`timescale 1ns/1ps
module mic_sync3 #(
	parameter W = 5
) (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Pin side
	input wire [W-1:0] pin_in,
	// Filtered level
	output reg [W-1:0] level
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	genvar i;

	always @(posedge clk) begin
		s1_reg <= pin_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// A bit changes only once the second and third stage agree
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (srst) begin
					level[i] <= 1'b0;
				end else if (s2_reg[i] == s3_reg[i]) begin
					level[i] <= s3_reg[i];
				end
			end
		end
	endgenerate
endmodule

//--- design/mic_stack.v
/*
 Return address stack: eight words of program counter, circular.
 Assumes push and pop are never asked in the same cycle.
*/
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_stack (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Push side
	input wire push,
	input wire [12:0] push_data,
	// Pop side
	input wire pop,
	output reg [12:0] top_data
);
	reg [12:0] mem [0:`MIC_STACK_DEPTH-1];
	reg [2:0] ptr_reg;
	wire [2:0] ptr_dec;

	assign ptr_dec = ptr_reg - 3'h1;

	always @(posedge clk) begin
		if (push) begin
			mem[ptr_reg] <= push_data;
		end
	end

	// Registered read of the current top word
	always @(posedge clk) begin
		if (srst) begin
			ptr_reg <= 3'h0;
			top_data <= `MIC_PC_RST;
		end else if (push) begin
			ptr_reg <= ptr_reg + 3'h1;
			top_data <= push_data;
		end else if (pop) begin
			ptr_reg <= ptr_dec;
			top_data <= mem[ptr_dec - 3'h1];
		end
	end
endmodule

//--- tb/mic_irq_properties.sv
/*
 Checker of the interrupt controller ports, bound into mic_irq_ctrl.
 Assumes the single clk domain and synchronous srst.
*/
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_irq_properties (
	// Clock and reset
	input wire clk,
	input wire srst,
	// AXI4-Lite handshakes
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Core side
	input wire return_from_irq_instr,
	input wire pc_load,
	input wire [12:0] pc_load_value,
	input wire core_asleep,
	input wire irq_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence s_wr_fire;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_ret;
		return_from_irq_instr && !core_asleep && !pc_load;
	endsequence
	property p_wr_answer;
		s_wr_fire |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write response missing");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read data late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	property p_load_pulse;
		pc_load |=> !pc_load;
	endproperty
	a_load_pulse: assert property (p_load_pulse)
		else $error("pc load longer than one cycle");
	property p_vector;
		pc_load && !$past(return_from_irq_instr, 2) |-> pc_load_value == `MIC_VECTOR;
	endproperty
	a_vector: assert property (p_vector)
		else $error("entry address wrong");
	property p_return;
		s_ret |-> ##2 pc_load;
	endproperty
	a_return: assert property (p_return)
		else $error("return address not loaded");
	property p_reset;
		disable iff (1'b0) srst |=> !pc_load && !irq_out && !core_asleep;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs active after reset");
	property p_sleep_still;
		core_asleep |-> !pc_load;
	endproperty
	a_sleep_still: assert property (p_sleep_still)
		else $error("pc loaded while asleep");
endmodule
bind mic_irq_ctrl mic_irq_properties u_mic_irq_properties (
	.clk(clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.return_from_irq_instr(return_from_irq_instr), .pc_load(pc_load),
	.pc_load_value(pc_load_value), .core_asleep(core_asleep),
	.irq_out(irq_out));

//--- tb/mic_core_model.sv
/*
 Core sequencer model: one instruction per four clocks.
 Assumes the bench requests returns and sleeps by one-cycle pulses.
*/
`timescale 1ns/1ps
module mic_core_model (
	input wire clk,
	input wire srst,
	input wire ret_req,
	input wire sleep_req,
	input wire pc_load,
	input wire [12:0] pc_load_value,
	input wire core_asleep,
	output reg instr_boundary,
	output reg return_from_irq_instr,
	output reg sleep_instr,
	output reg [12:0] return_pc
);
	reg [1:0] phase_reg;
	reg [12:0] pc_reg;
	reg ret_pend;
	reg sleep_pend;
	always @(posedge clk) begin
		instr_boundary <= 1'b0;
		return_from_irq_instr <= 1'b0;
		sleep_instr <= 1'b0;
		if (ret_req)
			ret_pend <= 1'b1;
		if (sleep_req)
			sleep_pend <= 1'b1;
		if (srst) begin
			phase_reg <= 2'h0;
			pc_reg <= 13'h0000;
			return_pc <= 13'h0000;
			ret_pend <= 1'b0;
			sleep_pend <= 1'b0;
		end else if (pc_load) begin
			pc_reg <= pc_load_value;
			phase_reg <= 2'h0;
		end else if (!core_asleep) begin
			phase_reg <= phase_reg + 2'h1;
			if (phase_reg == 2'h3) begin
				instr_boundary <= 1'b1;
				return_pc <= pc_reg + 13'h0001;
				pc_reg <= pc_reg + 13'h0001;
			end
			// Mid-instruction so a push never meets a pop
			if (phase_reg == 2'h1 && ret_pend) begin
				return_from_irq_instr <= 1'b1;
				ret_pend <= 1'b0;
			end else if (phase_reg == 2'h1 && sleep_pend) begin
				sleep_instr <= 1'b1;
				sleep_pend <= 1'b0;
			end
		end
	end
endmodule

//--- tb/tb.sv
/*
 Register-level bench of the interrupt controller.
 Assumes the core model drives the sequencer inputs.
*/
`timescale 1ns/1ps
`include "mic_defs.vh"
module tb;
	reg clk, srst, awvalid, wvalid, arvalid, pin, tmr, ee, ret_q, slp_q;
	reg bready, rready;
	reg [7:0] awaddr, araddr;
	reg [31:0] wdata, d;
	reg [3:0] port;
	reg [1:0] r;
	reg [12:0] last_pc, saved_pc;
	wire awready, wready, bvalid, arready, rvalid, pcl, asleep, irq;
	wire bnd, rfi, slp;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [12:0] pcv, rpc;
	integer miscompares = 0, n_tests = 0, n_load = 0, c, k;
	integer n_bnd = 0, b;
	mic_irq_ctrl u_mic_irq_ctrl (.clk(clk), .srst(srst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .external_irq_pin(pin),
		.second_io_port_hi(port), .timer_zero_overflow(tmr),
		.ee_write_done_flag(ee), .instr_boundary(bnd),
		.return_from_irq_instr(rfi), .sleep_instr(slp), .return_pc(rpc),
		.pc_load(pcl), .pc_load_value(pcv), .core_asleep(asleep),
		.irq_out(irq));
	mic_core_model u_mic_core_model (.clk(clk), .srst(srst),
		.ret_req(ret_q), .sleep_req(slp_q), .pc_load(pcl),
		.pc_load_value(pcv), .core_asleep(asleep), .instr_boundary(bnd),
		.return_from_irq_instr(rfi), .sleep_instr(slp), .return_pc(rpc));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (bnd)
			last_pc <= rpc;
		if (pcl)
			n_load <= n_load + 1;
		if (bnd)
			n_bnd <= n_bnd + 1;
	end
	// ------------------------------------------------------------
	// Reporting and bus tasks
	// ------------------------------------------------------------
	task complete_run;
		begin
			$display("tests %0d mismatches %0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("ERROR %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task timed_out;
		begin
			miscompares = miscompares + 1;
			$display("ERROR wait expected handshake seen none");
			complete_run;
		end
	endtask
	// Responses are accepted one cycle late so the hold rules are exercised
	task wr(input [7:0] a, input [31:0] v);
		reg ha, hw, dn, sb;
		begin
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			dn = 0;
			for (k = 0; k < 50 && !dn; k = k + 1) begin
				@(negedge clk);
				ha = awvalid && awready;
				hw = wvalid && wready;
				sb = bvalid;
				dn = bvalid && bready;
				r = bresp;
				@(posedge clk);
				if (ha)
					awvalid <= 1'b0;
				if (hw)
					wvalid <= 1'b0;
				if (sb && !dn)
					bready <= 1'b1;
				if (dn)
					bready <= 1'b0;
			end
			if (!dn)
				timed_out;
		end
	endtask
	task rd(input [7:0] a);
		reg ha, dn, sv;
		begin
			araddr <= a;
			arvalid <= 1'b1;
			dn = 0;
			for (k = 0; k < 50 && !dn; k = k + 1) begin
				@(negedge clk);
				ha = arvalid && arready;
				sv = rvalid;
				dn = rvalid && rready;
				d = rdata;
				r = rresp;
				@(posedge clk);
				if (ha)
					arvalid <= 1'b0;
				if (sv && !dn)
					rready <= 1'b1;
				if (dn)
					rready <= 1'b0;
			end
			if (!dn)
				timed_out;
		end
	endtask
	task wait_load;
		reg f;
		begin
			c = 0;
			f = 0;
			while (c < 60 && !f) begin
				@(negedge clk);
				c = c + 1;
				f = pcl;
			end
			if (!f)
				timed_out;
			@(posedge clk);
		end
	endtask
	task pin_to(input v);
		begin
			pin <= v;
			repeat (12) @(posedge clk);
		end
	endtask
	task look(input string nm, input [31:0] e, input [31:0] g);
		begin
			chk(nm, e, g);
			@(posedge clk);
		end
	endtask
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		{srst, awvalid, wvalid, arvalid, pin, tmr, ee, ret_q, slp_q} = 9'h100;
		{bready, rready} = 2'h0;
		{awaddr, araddr, wdata, port} = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		rd(`MIC_OFF_CTRL);
		chk("ctrl reset", 32'h00, d);
		rd(`MIC_OFF_OPTION);
		chk("option reset", 32'hFF, d);
		rd(8'h18);
		chk("unmapped rresp", `MIC_AXI_SLVERR, r);
		wr(`MIC_OFF_STAT, 32'h01);
		chk("status bresp", `MIC_AXI_SLVERR, r);
		$display("test reset done");
		tmr <= 1'b1;
		@(posedge clk);
		tmr <= 1'b0;
		repeat (2) @(posedge clk);
		rd(`MIC_OFF_CTRL);
		chk("timer flag", 32'h04, d);
		wr(`MIC_OFF_IEN, 32'h04);
		@(negedge clk);
		look("irq raised", 1, irq);
		wr(`MIC_OFF_IEN, 32'h00);
		@(negedge clk);
		look("irq masked", 0, irq);
		wr(`MIC_OFF_CLR, 32'h0F);
		rd(`MIC_OFF_STAT);
		chk("status cleared", 32'h00, d);
		$display("test timer done");
		wr(`MIC_OFF_CTRL, 32'h00);
		pin_to(1);
		rd(`MIC_OFF_CTRL);
		chk("rising edge", 32'h02, d);
		wr(`MIC_OFF_OPTION, 32'hBF);
		wr(`MIC_OFF_CTRL, 32'h00);
		pin_to(0);
		rd(`MIC_OFF_CTRL);
		chk("falling edge", 32'h02, d);
		wr(`MIC_OFF_CTRL, 32'h00);
		pin_to(1);
		rd(`MIC_OFF_CTRL);
		chk("ignored edge", 32'h00, d);
		port <= 4'hA;
		repeat (8) @(posedge clk);
		rd(`MIC_OFF_CTRL);
		chk("port change", 32'h01, d);
		$display("test flags done");
		wr(`MIC_OFF_CTRL, 32'h10);
		c = n_load;
		pin_to(0);
		chk("gated load", c, n_load);
		pin_to(1);
		wr(`MIC_OFF_CTRL, 32'h90);
		pin <= 1'b0;
		wait_load;
		saved_pc = last_pc;
		chk("latency", 1, c <= 16);
		chk("vector", `MIC_VECTOR, pcv);
		rd(`MIC_OFF_CTRL);
		chk("enable cleared", 0, d[7]);
		wr(`MIC_OFF_CTRL, 32'h10);
		ret_q <= 1'b1;
		@(posedge clk);
		ret_q <= 1'b0;
		wait_load;
		chk("return pc", saved_pc, pcv);
		rd(`MIC_OFF_CTRL);
		chk("enable set", 1, d[7]);
		wr(`MIC_OFF_CTRL, 32'hC0);
		ee <= 1'b1;
		wait_load;
		chk("eeprom vector", `MIC_VECTOR, pcv);
		ee <= 1'b0;
		$display("test entry done");
		wr(`MIC_OFF_CTRL, 32'h10);
		slp_q <= 1'b1;
		@(posedge clk);
		slp_q <= 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		look("asleep", 1, asleep);
		c = n_load;
		pin_to(1);
		pin_to(0);
		@(negedge clk);
		look("woken", 0, asleep);
		chk("no vector", c, n_load);
		$display("test sleep done");
		wr(`MIC_OFF_CTRL, 32'h90);
		slp_q <= 1'b1;
		@(posedge clk);
		slp_q <= 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		look("asleep enabled", 1, asleep);
		pin_to(1);
		b = n_bnd;
		pin <= 1'b0;
		wait_load;
		chk("wake then vector", 1, n_bnd - b >= 2);
		chk("wake vector", `MIC_VECTOR, pcv);
		$display("test wake done");
		complete_run;
	end
endmodule
